// ===== logic/pmic_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz core clock, 32-bit register words
// Notes: byte address of a register is four times its index
`ifndef PMIC_MAP_SVH
`define PMIC_MAP_SVH
`define PMIC_GAIN_IDX 4'h0
`define PMIC_INTCFG_IDX 4'h1
`define PMIC_CTRL_IDX 4'h2
`define PMIC_STATUS_IDX 4'h3
`define PMIC_RESULT_IDX 4'h4
`define PMIC_SAMPLES_IDX 4'h5
`define PMIC_CG_LSB 0
`define PMIC_VG_LSB 3
`define PMIC_SAMP_LSB 0
`define PMIC_SEL_LSB 4
`define PMIC_INTEN_BIT 0
`define PMIC_OVR_BIT 1
`define PMIC_RANGE_LSB 2
`define PMIC_SLEEP_BIT 4
`define PMIC_GAIN_RST 3'h0
`define PMIC_SEL_RST 2'h0
`define PMIC_RANGE_RST 2'h0
`define PMIC_SAMP_RST 4'h0
`define PMIC_VG_MAX 3'h5
`define PMIC_SAMP_MAX 4'hB
`define PMIC_SAMPLE_SAT 12'h800
`define PMIC_FULL_SCALE 16'hFFC0
`define PMIC_RESP_OKAY 2'h0
`define PMIC_RESP_SLVERR 2'h2
`define PMIC_CLK_MHZ 100
`define PMIC_UPDATE_HOLD_NS 1000
`define PMIC_READ_HOLD_NS 10000
`define PMIC_R2I_DELAY_NS 30000
`define PMIC_UPDATE_CYC ((`PMIC_UPDATE_HOLD_NS * `PMIC_CLK_MHZ + 999) / 1000)
`define PMIC_READ_CYC ((`PMIC_READ_HOLD_NS * `PMIC_CLK_MHZ + 999) / 1000)
`define PMIC_R2I_CYC ((`PMIC_R2I_DELAY_NS * `PMIC_CLK_MHZ + 999) / 1000)
`endif

// ===== logic/pmic_pkg.sv
// Purpose: types shared by the integration controller
// Assumes: nothing beyond the map header
// Notes: state codes are Gray along idle, delay, integrate, calc, read
package pmic_pkg;
    typedef enum logic [2:0] {
        PMIC_IDLE = 3'h0,
        PMIC_DELAY = 3'h1,
        PMIC_INTEG = 3'h3,
        PMIC_CALC = 3'h2,
        PMIC_READ = 3'h6
    } pmic_state_t;
    typedef enum logic [1:0] {
        PMIC_PIN_POWER = 2'h0,
        PMIC_FREE_SENSE = 2'h1,
        PMIC_FREE_BUS = 2'h2,
        PMIC_FREE_POWER = 2'h3
    } pmic_sel_t;
endpackage

// ===== logic/pmic_ctrl.sv
// Purpose: integration, averaging, gain and DAC latch of a power monitor
// Assumes: ADC samples arrive on this clock; control pin is asynchronous
// Notes: registers over AXI4-Lite; no interrupt, no buffering
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "pmic_map.svh"
module pmic_ctrl #(
    parameter int UPDATE_CYC = `PMIC_UPDATE_CYC,
    parameter int READ_CYC = `PMIC_READ_CYC,
    parameter int R2I_CYC = `PMIC_R2I_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic read_int_pin_i,
    input wire logic sample_valid_i,
    input wire logic [15:0] vbus_sample_i,
    input wire logic [15:0] vsense_sample_i,
    output logic [9:0] dac_code_o,
    output logic dac_load_o,
    output logic [1:0] output_range_o,
    output logic integrating_o,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************************************
    // Configuration registers
    // ****************************************
    logic [2:0] current_gain;
    logic [2:0] voltage_gain;
    logic [3:0] sample_count_field;
    logic [1:0] output_select_field;
    logic [1:0] output_range_field;
    logic pin_override_bit;
    logic int_en;
    logic sleep_cmd;
    // ****************************************
    // Measurement state
    // ****************************************
    pmic_pkg::pmic_state_t state;
    logic [27:0] acc;
    logic [11:0] cnt;
    logic [15:0] result;
    logic [11:0] low_cnt;
    logic [11:0] delay_cnt;
    logic deep_read;
    logic [27:0] div_num;
    logic [11:0] div_den;
    logic [4:0] div_step;
    logic [12:0] div_rem;
    logic pin_ff1;
    logic pin_ff2;
    logic pin_ff3;
    logic pin_level;
    // ****************************************
    // Bus slave state
    // ****************************************
    logic aw_full;
    logic w_full;
    logic [3:0] aw_idx;
    logic aw_ok;
    logic [7:0] w_byte0;
    logic w_en0;
    logic [3:0] ar_idx;
    logic ar_ok;
    // Control pin: three stages, change accepted once last two agree
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_ff1 <= 1'b0;
            pin_ff2 <= 1'b0;
            pin_ff3 <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            pin_ff1 <= read_int_pin_i;
            pin_ff2 <= pin_ff1;
            pin_ff3 <= pin_ff2;
            if (pin_ff2 == pin_ff3) begin
                pin_level <= pin_ff3;
            end
        end
    end
    logic integ_req;
    logic free_run;
    logic low_seen;
    logic read_seen;
    logic [11:0] target;
    logic [31:0] prod;
    logic [15:0] sample;
    logic [12:0] rem_sh;
    logic [15:0] avg;
    logic [27:0] gained;
    logic [3:0] shift;
    logic [2:0] vg_eff;
    logic [3:0] samp_eff;
    assign integ_req = pin_override_bit ? int_en : pin_level;
    assign free_run = (output_select_field != pmic_pkg::PMIC_PIN_POWER);
    assign low_seen = pin_override_bit ? !int_en : (low_cnt >= 12'(UPDATE_CYC));
    assign read_seen = pin_override_bit ? !int_en : (low_cnt >= 12'(READ_CYC));
    assign samp_eff = (sample_count_field > `PMIC_SAMP_MAX) ? `PMIC_SAMP_MAX
        : sample_count_field;
    // Pin mode runs to saturation unless the host ends it first
    assign target = free_run ? (12'h001 << samp_eff) : `PMIC_SAMPLE_SAT;
    assign prod = vbus_sample_i * vsense_sample_i;
    always_comb begin
        unique case (output_select_field)
            pmic_pkg::PMIC_FREE_SENSE: sample = vsense_sample_i;
            pmic_pkg::PMIC_FREE_BUS: sample = vbus_sample_i;
            pmic_pkg::PMIC_PIN_POWER, pmic_pkg::PMIC_FREE_POWER: sample = prod[31:16];
        endcase
    end
    assign vg_eff = (voltage_gain > `PMIC_VG_MAX) ? `PMIC_VG_MAX : voltage_gain;
    always_comb begin
        unique case (output_select_field)
            pmic_pkg::PMIC_FREE_SENSE: shift = {1'b0, current_gain};
            pmic_pkg::PMIC_FREE_BUS: shift = {1'b0, vg_eff};
            pmic_pkg::PMIC_PIN_POWER, pmic_pkg::PMIC_FREE_POWER:
                shift = {1'b0, current_gain} + {1'b0, vg_eff};
        endcase
    end
    assign rem_sh = {div_rem[11:0], div_num[27]};
    // Last divider step folded into the gain stage
    assign avg = (div_den == 12'h000) ? 16'h0000
        : {div_num[14:0], (rem_sh >= {1'b0, div_den})};
    assign gained = {12'h000, avg} << shift;
    // Timer counting low time on the control input
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_cnt <= 12'h000;
        end else if (integ_req) begin
            low_cnt <= 12'h000;
        end else if (low_cnt != 12'hFFF) begin
            low_cnt <= low_cnt + 12'h001;
        end
    end
    // ****************************************
    // Integration state machine
    // ****************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= pmic_pkg::PMIC_IDLE;
            acc <= 28'h0000000;
            cnt <= 12'h000;
            result <= 16'h0000;
            dac_code_o <= 10'h000;
            dac_load_o <= 1'b0;
            delay_cnt <= 12'h000;
            deep_read <= 1'b0;
            div_num <= 28'h0000000;
            div_den <= 12'h000;
            div_rem <= 13'h0000;
            div_step <= 5'h00;
        end else begin
            dac_load_o <= 1'b0;
            if (sleep_cmd) begin
                state <= pmic_pkg::PMIC_IDLE;
                acc <= 28'h0000000;
                cnt <= 12'h000;
                result <= 16'h0000;
                dac_code_o <= 10'h000;
            end else begin
                unique case (state)
                    pmic_pkg::PMIC_IDLE: begin
                        if (integ_req) begin
                            delay_cnt <= 12'h000;
                            state <= pmic_pkg::PMIC_DELAY;
                        end
                    end
                    pmic_pkg::PMIC_DELAY: begin
                        // Transition time is not part of the period
                        if (!integ_req) begin
                            state <= pmic_pkg::PMIC_READ;
                        end else if (delay_cnt >= 12'(R2I_CYC - 1)) begin
                            state <= pmic_pkg::PMIC_INTEG;
                        end else begin
                            delay_cnt <= delay_cnt + 12'h001;
                        end
                    end
                    pmic_pkg::PMIC_INTEG: begin
                        if (low_seen && free_run) begin
                            acc <= 28'h0000000;
                            cnt <= 12'h000;
                            deep_read <= 1'b0;
                            state <= pmic_pkg::PMIC_READ;
                        end else if (low_seen || cnt >= target) begin
                            div_num <= acc;
                            div_den <= cnt;
                            div_rem <= 13'h0000;
                            div_step <= 5'h00;
                            state <= pmic_pkg::PMIC_CALC;
                        end else if (sample_valid_i) begin
                            acc <= acc + {12'h000, sample};
                            cnt <= cnt + 12'h001;
                        end
                    end
                    pmic_pkg::PMIC_CALC: begin
                        if (div_step == 5'h1B) begin
                            if (gained > {12'h000, `PMIC_FULL_SCALE}) begin
                                result <= `PMIC_FULL_SCALE;
                                dac_code_o <= 10'(`PMIC_FULL_SCALE >> 6);
                            end else begin
                                result <= gained[15:0];
                                dac_code_o <= gained[15:6];
                            end
                            dac_load_o <= 1'b1;
                            acc <= 28'h0000000;
                            cnt <= 12'h000;
                            deep_read <= 1'b0;
                            // Short low pulse resumes with no restart delay
                            state <= integ_req ? pmic_pkg::PMIC_INTEG
                                : pmic_pkg::PMIC_READ;
                        end else begin
                            if (rem_sh >= {1'b0, div_den}) begin
                                div_rem <= rem_sh - {1'b0, div_den};
                                div_num <= {div_num[26:0], 1'b1};
                            end else begin
                                div_rem <= rem_sh;
                                div_num <= {div_num[26:0], 1'b0};
                            end
                            div_step <= div_step + 5'h01;
                        end
                    end
                    pmic_pkg::PMIC_READ: begin
                        if (integ_req) begin
                            delay_cnt <= 12'h000;
                            state <= (deep_read || pin_override_bit) ? pmic_pkg::PMIC_DELAY
                                : pmic_pkg::PMIC_INTEG;
                        end else if (read_seen) begin
                            deep_read <= 1'b1;
                        end
                    end
                    default: state <= pmic_pkg::PMIC_IDLE;
                endcase
            end
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            integrating_o <= 1'b0;
            output_range_o <= `PMIC_RANGE_RST;
        end else begin
            integrating_o <= (state == pmic_pkg::PMIC_INTEG);
            output_range_o <= output_range_field;
        end
    end
    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_idx <= 4'h0;
            aw_ok <= 1'b0;
            w_byte0 <= 8'h00;
            w_en0 <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PMIC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_idx <= s_axi_awaddr[5:2];
                aw_ok <= (s_axi_awaddr[31:2] <= {26'h0, `PMIC_SAMPLES_IDX});
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_byte0 <= s_axi_wdata[7:0];
                w_en0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (aw_full && w_full && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_ok ? `PMIC_RESP_OKAY : `PMIC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    logic wr_go;
    assign wr_go = aw_full && w_full && !s_axi_bvalid && w_en0 && aw_ok;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            current_gain <= `PMIC_GAIN_RST;
            voltage_gain <= `PMIC_GAIN_RST;
            sample_count_field <= `PMIC_SAMP_RST;
            output_select_field <= `PMIC_SEL_RST;
            output_range_field <= `PMIC_RANGE_RST;
            pin_override_bit <= 1'b0;
            int_en <= 1'b0;
            sleep_cmd <= 1'b0;
        end else begin
            sleep_cmd <= 1'b0;
            if (wr_go && aw_idx == `PMIC_GAIN_IDX) begin
                current_gain <= w_byte0[`PMIC_CG_LSB +: 3];
                voltage_gain <= w_byte0[`PMIC_VG_LSB +: 3];
            end
            if (wr_go && aw_idx == `PMIC_INTCFG_IDX) begin
                sample_count_field <= w_byte0[`PMIC_SAMP_LSB +: 4];
                output_select_field <= w_byte0[`PMIC_SEL_LSB +: 2];
            end
            if (wr_go && aw_idx == `PMIC_CTRL_IDX) begin
                int_en <= w_byte0[`PMIC_INTEN_BIT];
                pin_override_bit <= w_byte0[`PMIC_OVR_BIT];
                output_range_field <= w_byte0[`PMIC_RANGE_LSB +: 2];
                sleep_cmd <= w_byte0[`PMIC_SLEEP_BIT];
            end
        end
    end
    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h00000000;
        if (ar_ok) begin
            unique case (ar_idx)
                `PMIC_GAIN_IDX: rd_word = {26'h0, voltage_gain, current_gain};
                `PMIC_INTCFG_IDX: rd_word = {26'h0, output_select_field, sample_count_field};
                `PMIC_CTRL_IDX: rd_word = {28'h0, output_range_field, pin_override_bit, int_en};
                `PMIC_STATUS_IDX: rd_word = {13'h0, state, 6'h00, dac_code_o};
                `PMIC_RESULT_IDX: rd_word = {16'h0000, result};
                `PMIC_SAMPLES_IDX: rd_word = {20'h00000, cnt};
                default: rd_word = 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ar_idx <= 4'h0;
            ar_ok <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            ar_idx <= s_axi_araddr[5:2];
            ar_ok <= (s_axi_araddr[31:2] <= {26'h0, `PMIC_SAMPLES_IDX});
        end
    end
    // Address is held one cycle so data reflects state after the take
    logic ar_pend;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ar_pend <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PMIC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                ar_pend <= 1'b1;
            end
            if (ar_pend) begin
                ar_pend <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= ar_ok ? `PMIC_RESP_OKAY : `PMIC_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// ===== dv/pmic_ctrl_properties.sv
// Purpose: port assertions for the integration controller
// Assumes: one clock domain, async active-low reset
// Notes: bound to every pmic_ctrl instance
`timescale 1ns/1ps
`include "pmic_map.svh"
module pmic_ctrl_checker #(
    parameter int UPDATE_CYC = `PMIC_UPDATE_CYC,
    parameter int READ_CYC = `PMIC_READ_CYC,
    parameter int R2I_CYC = `PMIC_R2I_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [9:0] dac_code_o,
    input wire logic dac_load_o,
    input wire logic [1:0] output_range_o,
    input wire logic integrating_o,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // Sleep clears to zero without a pulse, so zero is exempt
    a_code_on_load: assert property ($changed(dac_code_o) && dac_code_o != 10'h000 |-> dac_load_o)
        else $error("code moved without load");
    a_load_single: assert property (dac_load_o |=> !dac_load_o)
        else $error("load pulse too long");
    a_load_after_calc: assert property (dac_load_o |-> !integrating_o && !$past(integrating_o, 20))
        else $error("load while integrating");
    a_range_on_write: assert property ($changed(output_range_o) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("range moved without write");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid)
        else $error("read not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    c_load: cover property (dac_load_o);
    c_integ: cover property ($rose(integrating_o));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind pmic_ctrl pmic_ctrl_checker #(.UPDATE_CYC(UPDATE_CYC), .READ_CYC(READ_CYC),
    .R2I_CYC(R2I_CYC)) i_pmic_ctrl_checker (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .dac_code_o(dac_code_o), .dac_load_o(dac_load_o), .output_range_o(output_range_o),
    .integrating_o(integrating_o), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// ===== dv/pmic_host_model.sv
// Purpose: host driving the control pin and sampling the output
// Assumes: pin changes just after a rising edge
// Notes: output is read only after the settle time
`timescale 1ns/1ps
module pmic_host_model #(
    parameter int SETTLE_CYC = 3
) (
    input wire logic clk_i,
    input wire logic [9:0] dac_code_i,
    input wire logic dac_load_i,
    output logic pin_o,
    output logic [9:0] seen_o
);
    // ****************
    // Host behaviour
    // ****************
    int wait_cnt = -1;
    initial pin_o = 1'b0;
    initial seen_o = 10'h000;
    // Reading early would catch the buffer mid-slew
    always @(posedge clk_i) begin
        if (dac_load_i) begin
            wait_cnt <= SETTLE_CYC;
        end else if (wait_cnt == 0) begin
            seen_o <= dac_code_i;
            wait_cnt <= -1;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
    task automatic hold_low(input int n, input logic back);
        pin_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        pin_o <= back;
    endtask
    task automatic set_pin(input logic v);
        pin_o <= v;
    endtask
endmodule

// ===== dv/test_power_monitor_integration_ctrl.sv
// Purpose: self-checking bench for the integration controller
// Assumes: short hold and delay counts
// Notes: expected codes come from the bench's own averaging
`timescale 1ns/1ps
`include "pmic_map.svh"
module test_power_monitor_integration_ctrl;
    // ****************
    // Stimulus and checks
    // ****************
    localparam int RD = 10;
    localparam int R2I = 200;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic pin, ld, integ, bv, rv, awr, wr, arr;
    logic sv = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [15:0] vb = 16'h0000, vs = 16'h0000;
    logic [9:0] code, seen;
    logic [1:0] rng, bresp, rresp, bq, rq;
    logic [31:0] aw = 32'h0, wd = 32'h0, ar = 32'h0, rdata, rd;
    logic [47:0] sb, ss, sp;
    int fails = 0, cmp_count = 0, cyc = 0, loads = 0, seed = 52;
    pmic_ctrl #(.UPDATE_CYC(4), .READ_CYC(RD), .R2I_CYC(R2I)) i_pmic_ctrl (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .read_int_pin_i(pin), .sample_valid_i(sv),
        .vbus_sample_i(vb), .vsense_sample_i(vs), .dac_code_o(code), .dac_load_o(ld),
        .output_range_o(rng), .integrating_o(integ), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
    pmic_host_model i_pmic_host_model (.clk_i(clk_i), .dac_code_i(code), .dac_load_i(ld),
        .pin_o(pin), .seen_o(seen));
    initial forever #5 clk_i = ~clk_i;
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        loads <= loads + int'(ld);
        if (cyc == 30000) begin
            fails = fails + 1;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Wait for load (w=1) or integrate flag, bounded
    task automatic wt(input bit w, input int lim);
        int n;
        n = 0;
        while ((w ? ld : integ) !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, (w ? ld : integ)}, 32'h1);
    endtask
    task automatic wr_reg(input logic [3:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        aw <= {26'h0, idx, 2'h0};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1 && n < 64);
        br <= 1'b0;
        bq = bresp;
        chk({31'h0, bv}, 32'h1);
    endtask
    task automatic rd_reg(input logic [3:0] idx);
        int n;
        n = 0;
        @(posedge clk_i);
        ar <= {26'h0, idx, 2'h0};
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 64);
        rr <= 1'b0;
        rd = rdata;
        rq = rresp;
    endtask
    // Sums restart with every batch
    task automatic feed(input int n);
        logic [15:0] b;
        logic [15:0] s;
        sb = 0;
        ss = 0;
        sp = 0;
        repeat (n) begin
            b = 16'($random(seed));
            s = 16'($random(seed));
            @(posedge clk_i);
            vb <= b;
            vs <= s;
            sv <= 1'b1;
            @(posedge clk_i);
            sv <= 1'b0;
            sb += 48'(b);
            ss += 48'(s);
            sp += 48'((32'(b) * 32'(s)) >> 16);
        end
    endtask
    function automatic logic [31:0] exp_code(input logic [1:0] sel, input logic [2:0] cg,
        input logic [2:0] vg, input int cnt);
        logic [63:0] v;
        int sh;
        sh = (vg > 3'h5) ? 5 : int'(vg);
        v = (sel == 2'h1) ? 64'(ss) : (sel == 2'h2) ? 64'(sb) : 64'(sp);
        v = (v / cnt) << ((sel == 2'h1) ? int'(cg) : (sel == 2'h2) ? sh : sh + int'(cg));
        if (v > 64'hFFC0) v = 64'hFFC0;
        return {22'h0, v[15:6]};
    endfunction
    task automatic run_free(input logic [1:0] sel, input logic [2:0] cg, input logic [2:0] vg,
        input logic [3:0] sm, input bit junk);
        int k;
        int n;
        n = (sm > 4'hB) ? 2048 : (1 << sm);
        wr_reg(`PMIC_CTRL_IDX, 32'h2);
        wr_reg(`PMIC_GAIN_IDX, {26'h0, vg, cg});
        wr_reg(`PMIC_INTCFG_IDX, {26'h0, sel, sm});
        wr_reg(`PMIC_CTRL_IDX, 32'h3);
        wt(1'b0, R2I + 50);
        if (junk) begin
            k = loads;
            feed(1);
            wr_reg(`PMIC_CTRL_IDX, 32'h2);
            repeat (40) @(posedge clk_i);
            chk(32'(loads), 32'(k));
            wr_reg(`PMIC_CTRL_IDX, 32'h3);
            wt(1'b0, R2I + 50);
        end
        feed(n);
        wt(1'b1, 100);
        chk({22'h0, code}, exp_code(sel, cg, vg, n));
        wt(1'b0, 20);
        repeat (5) @(posedge clk_i);
        chk({22'h0, seen}, exp_code(sel, cg, vg, n));
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rd_reg(4'(i));
            chk(rd, 32'h0);
        end
        rd_reg(4'h6);
        chk({rd[29:0], rq}, {30'h0, `PMIC_RESP_SLVERR});
        wr_reg(4'h7, 32'hF);
        chk({30'h0, bq}, {30'h0, `PMIC_RESP_SLVERR});
        for (int r = 0; r < 4; r++) begin
            wr_reg(`PMIC_CTRL_IDX, 32'(r) << 2);
            repeat (2) @(posedge clk_i);
            chk({30'h0, rng}, 32'(r));
        end
        for (int i = 0; i < 6; i++) begin
            run_free(2'(i % 3 + 1), 3'($random(seed)), 3'($random(seed)), 4'(i % 3),
                i == 4);
        end
        run_free(2'h3, 3'h7, 3'h7, 4'h1, 1'b1);
        run_free(2'h2, 3'h0, 3'h2, 4'hC, 1'b0);
        wr_reg(`PMIC_CTRL_IDX, 32'h0);
        wr_reg(`PMIC_GAIN_IDX, 32'hA);
        wr_reg(`PMIC_INTCFG_IDX, 32'h0);
        i_pmic_host_model.set_pin(1'b1);
        wt(1'b0, R2I + 50);
        feed(3);
        i_pmic_host_model.hold_low(8, 1'b1);
        wt(1'b1, 100);
        chk({22'h0, code}, exp_code(2'h0, 3'h2, 3'h1, 3));
        wt(1'b0, 20);
        feed(2);
        fork
            i_pmic_host_model.hold_low(RD + 40, 1'b1);
            wt(1'b1, 100);
        join
        chk({22'h0, code}, exp_code(2'h0, 3'h2, 3'h1, 2));
        repeat (40) @(posedge clk_i);
        chk({31'h0, integ}, 32'h0);
        i_pmic_host_model.set_pin(1'b0);
        wr_reg(`PMIC_CTRL_IDX, 32'h10);
        rd_reg(`PMIC_STATUS_IDX);
        chk({22'h0, code | rd[9:0]}, 32'h0);
        rd_reg(`PMIC_RESULT_IDX);
        chk(rd, 32'h0);
        print_verdict();
    end
endmodule
